// [ptg_top.sv]
`timescale 1ns/1ps

// Notes on behaviour
// - Chain of 18 stages advances on each synchronised reference clock rising edge.
// - Run enable low holds every chain stage at zero.
// - Chain starts advancing once run enable is written one.
// - Rising edge at the selected tap sets the period flag.
// - Interrupt request is raised while flag and interrupt enable are both set.
// - Writing one to acknowledge clears the flag; zero does nothing.
// - Acknowledge bit stores nothing and always reads zero.
// - First flag after enable at half period, later ones every full period.
// - Rate codes 0 to 7 divide by 262144 down to 8.
// - Reset clears interrupt enable.
// - Reset clears run enable, leaving the chain zeroed.
// - Flag is read only; only acknowledge clears it.
// - Clearing then setting run enable restarts the chain from zero.
// - In wait mode chain keeps running; register is locked from the CPU.
// - In stop mode with oscillator kept alive, chain and wake request run.
// - In stop mode without oscillator the chain idles; register locked.
module ptg_top
  import ptg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic osc_ref_clock,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic stop_osc_keep_running,
  input wire logic [PTG_ADDR_W-1:0] reg_addr,
  input wire logic [PTG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PTG_DATA_W-1:0] reg_rdata,
  output logic period_irq
);

  logic [PTG_SYNC_STAGES-1:0] osc_sync_q;
  logic osc_last_q;
  logic [PTG_STAGES-1:0] chain_q;
  logic [PTG_STAGES-1:0] chain_d;
  logic [PTG_STAGES-1:0] chain_inc;
  logic run_q;
  logic run_d;
  logic ie_q;
  logic ie_d;
  logic flag_q;
  logic flag_d;
  logic [PTG_RATE_W-1:0] rate_q;
  logic [PTG_RATE_W-1:0] rate_d;
  logic [PTG_DATA_W-1:0] rdata_q;
  logic [PTG_DATA_W-1:0] rdata_d;
  logic irq_q;

  wire osc_rise;
  wire chain_alive;
  wire tick;
  wire [PTG_TAP_W-1:0] tap;
  wire tap_rise;
  wire cpu_open;
  wire addr_hit;
  wire wr_hit;
  wire rd_hit;
  wire ack;
  wire [PTG_DATA_W-1:0] ctrl_view;

  // Reference clock pin: two flops, then a third for edge detection
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_sync_q <= '0;
      osc_last_q <= 1'b0;
    end
    else
    begin
      osc_sync_q <= {osc_sync_q[PTG_SYNC_STAGES-2:0], osc_ref_clock};
      osc_last_q <= osc_sync_q[PTG_SYNC_STAGES-1];
    end
  end

  assign osc_rise = osc_sync_q[PTG_SYNC_STAGES-1] & ~osc_last_q;

  // Oscillator is gone in stop mode unless kept alive
  assign chain_alive = ~stop_mode | stop_osc_keep_running;
  assign tick = run_q & chain_alive & osc_rise;

  assign chain_inc = chain_q + {{(PTG_STAGES-1){1'b0}}, 1'b1};
  assign chain_d = !run_q ? '0 : (tick ? chain_inc : chain_q);

  // Rising edge of the tap bit: half period first, full period after
  assign tap = PTG_TAP[rate_q];
  assign tap_rise = tick & ~chain_q[tap] & chain_inc[tap];

  // CPU cannot reach the register in wait or stop mode
  assign cpu_open = ~wait_mode & ~stop_mode;
  assign addr_hit = reg_addr == PTG_CTRL_ADDR;
  assign wr_hit = reg_wr & cpu_open & addr_hit;
  assign rd_hit = reg_rd & cpu_open & addr_hit;
  assign ack = wr_hit & reg_wdata[PTG_ACK_BIT];

  // Set wins over acknowledge
  assign flag_d = tap_rise | (flag_q & ~ack);

  assign run_d = wr_hit ? reg_wdata[PTG_RUN_BIT] : run_q;
  assign ie_d = wr_hit ? reg_wdata[PTG_IE_BIT] : ie_q;
  assign rate_d = wr_hit ? reg_wdata[PTG_RATE_HI:PTG_RATE_LO] : rate_q;

  // Acknowledge and bit 0 always read zero
  assign ctrl_view = {flag_q, rate_q, 1'b0, ie_q, run_q, 1'b0};
  assign rdata_d = rd_hit ? ctrl_view : '0;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      run_q <= PTG_CTRL_RESET[PTG_RUN_BIT];
      ie_q <= PTG_CTRL_RESET[PTG_IE_BIT];
      flag_q <= PTG_CTRL_RESET[PTG_FLAG_BIT];
      rate_q <= PTG_RATE_RESET;
    end
    else
    begin
      run_q <= run_d;
      ie_q <= ie_d;
      flag_q <= flag_d;
      rate_q <= rate_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      chain_q <= '0;
    else
      chain_q <= chain_d;
  end

  // Request also serves as the stop mode wake source
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      irq_q <= flag_q & ie_q;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign period_irq = irq_q;

  chain_zero_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !run_q |=> chain_q == '0)
    else $error("chain not zero while stopped");

  run_start_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_hit && reg_wdata[PTG_RUN_BIT] ##1 tick |=> chain_q != '0)
    else $error("chain did not advance after enable");

  flag_set_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    tap_rise |=> flag_q ##1 (flag_q || $past(ack)))
    else $error("flag not set at tap overflow");

  irq_follow_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    period_irq == $past(flag_q && ie_q))
    else $error("request does not follow flag and enable");

  ack_clear_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    ack && !tap_rise |=> !flag_q ##1 !period_irq)
    else $error("acknowledge did not clear flag");

  ack_reads_zero_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    rd_hit |=> !reg_rdata[PTG_ACK_BIT] && !reg_rdata[0]
      && reg_rdata[PTG_RUN_BIT] == $past(run_q))
    else $error("read word malformed");

  tap_phase_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    tap_rise |-> chain_inc[tap]
      && (chain_inc & ((18'h0_0001 << tap) - 18'h0_0001)) == '0)
    else $error("period event off its tap phase");

  flag_ro_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_hit && !ack && !tap_rise |=> flag_q == $past(flag_q))
    else $error("write altered the flag");

  no_lose_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    tap_rise && ack |=> flag_q)
    else $error("event lost under acknowledge");

  locked_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wait_mode || stop_mode) |=> $stable(run_q) && $stable(ie_q)
      && $stable(rate_q) && reg_rdata == '0)
    else $error("register reached in low power mode");

  stop_idle_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    stop_mode && !stop_osc_keep_running && run_q |=> $stable(chain_q))
    else $error("chain advanced with oscillator stopped");

endmodule

// [ptg_pkg.sv]
package ptg_pkg;

  // Divider chain length
  localparam int unsigned PTG_STAGES = 18;

  // Synchroniser depth for the reference clock pin
  localparam int unsigned PTG_SYNC_STAGES = 2;

  // Register bus
  localparam int unsigned PTG_ADDR_W = 4;
  localparam int unsigned PTG_DATA_W = 8;
  localparam logic [PTG_ADDR_W-1:0] PTG_CTRL_ADDR = 4'h0;

  // Control register layout
  localparam int unsigned PTG_FLAG_BIT = 7;
  localparam int unsigned PTG_RATE_HI = 6;
  localparam int unsigned PTG_RATE_LO = 4;
  localparam int unsigned PTG_ACK_BIT = 3;
  localparam int unsigned PTG_IE_BIT = 2;
  localparam int unsigned PTG_RUN_BIT = 1;
  localparam int unsigned PTG_RATE_W = PTG_RATE_HI - PTG_RATE_LO + 1;
  localparam int unsigned PTG_TAP_W = 5;

  // Reset values
  localparam logic [PTG_DATA_W-1:0] PTG_CTRL_RESET = 8'h00;
  localparam logic [PTG_RATE_W-1:0] PTG_RATE_RESET = 3'h0;

  // Chain bit whose rising edge marks one period; divide ratio is 2^(tap+1):
  // 262144, 131072, 65536, 32768, 64, 32, 16, 8 for codes 0 to 7
  localparam logic [PTG_TAP_W-1:0] PTG_TAP [8] = '{
    5'h11, 5'h10, 5'h0f, 5'h0e, 5'h05, 5'h04, 5'h03, 5'h02
  };

endpackage

// [ptg_irq_model.sv]
`timescale 1ns/1ps
module ptg_irq_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic period_irq,
  output int wake_cnt
);
  logic seen_q;
  // Each new request counts as one wake event
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      seen_q <= 1'b0;
      wake_cnt <= 0;
    end
    else
    begin
      seen_q <= period_irq;
      if (period_irq && !seen_q)
        wake_cnt <= wake_cnt + 1;
    end
endmodule

// [ptg_top_tb.sv]
`timescale 1ns/1ps
module ptg_top_tb;
  import ptg_pkg::*;
  logic sys_clk = 0, rst = 1, osc_ref_clock = 0, wait_mode = 0, stop_mode = 0;
  logic stop_osc_keep_running = 0, reg_wr = 0, reg_rd = 0, period_irq;
  logic [PTG_ADDR_W-1:0] reg_addr = '0;
  logic [PTG_DATA_W-1:0] reg_wdata = '0, reg_rdata, w0;
  logic [1:0] ph = '0;
  int n_errors = 0, check_count = 0, seed = 37731, wake_cnt, t, c0;
  time t1;
  always #25 sys_clk = ~sys_clk;
  // Reference clock at a quarter of the system rate
  always @(posedge sys_clk)
  begin
    ph <= ph + 2'h1;
    osc_ref_clock <= ph[1];
  end
  ptg_top i_ptg_top (.sys_clk(sys_clk), .rst(rst), .osc_ref_clock(osc_ref_clock),
    .wait_mode(wait_mode), .stop_mode(stop_mode),
    .stop_osc_keep_running(stop_osc_keep_running), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .period_irq(period_irq));
  ptg_irq_model i_ptg_irq_model (.sys_clk(sys_clk), .rst(rst), .period_irq(period_irq),
    .wake_cnt(wake_cnt));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic wirq(input logic v, input int n);
    t = 0;
    while (period_irq !== v && t < n)
    begin
      @(posedge sys_clk);
      #1 t++;
    end
    chk(8'(period_irq), 8'(v));
  endtask
  function automatic int per_cycles(input int r);
    return 4 * ((r < 4) ? (262144 >> r) : (64 >> (r - 4)));
  endfunction
  task automatic end_of_test;
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    end_of_test;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 rd(0, 8'h00);
    for (int r = 0; r < 8; r++)
    begin
      w0 = 8'($random(seed));
      wr(0, {w0[7], r[2:0], 1'b0, w0[2], 1'b0, w0[0]});
      rd(0, {1'b0, r[2:0], 1'b0, w0[2], 2'b00});
      wr(4'h5, w0);
      rd(4'h5, 8'h00);
    end
    for (int r = 4; r < 8; r++)
    begin
      wr(0, {1'b0, r[2:0], 4'b0110});
      wirq(1, per_cycles(r));
      chk(8'(t + 4 >= per_cycles(r) / 2 && t <= per_cycles(r) / 2 + 8), 8'h01);
      t1 = $time;
      rd(0, {1'b1, r[2:0], 4'b0110});
      wr(0, {1'b0, r[2:0], 4'b0110});
      rd(0, {1'b1, r[2:0], 4'b0110});
      wr(0, {1'b0, r[2:0], 4'b1110});
      wirq(0, 3);
      wirq(1, per_cycles(r));
      chk(8'(($time - t1) / 50 == per_cycles(r)), 8'h01);
      wr(0, 8'h08);
    end
    wr(0, 8'h74);
    repeat (100) @(posedge sys_clk);
    #1 chk(8'(period_irq), 8'h00);
    wr(0, 8'h76);
    wait_mode <= 1'b1;
    rd(0, 8'h00);
    wr(0, 8'h00);
    wirq(1, 40);
    wait_mode <= 1'b0;
    rd(0, 8'hf6);
    wr(0, 8'h7e);
    stop_mode <= 1'b1;
    repeat (100) @(posedge sys_clk);
    #1 chk(8'(period_irq), 8'h00);
    rd(0, 8'h00);
    c0 = wake_cnt;
    stop_osc_keep_running <= 1'b1;
    wirq(1, 40);
    @(posedge sys_clk);
    #1 chk(8'(wake_cnt - c0), 8'h01);
    stop_mode <= 1'b0;
    wr(0, 8'h08);
    stop_mode <= 1'b1;
    repeat (50) @(posedge sys_clk);
    #1 chk(8'(period_irq), 8'h00);
    end_of_test;
  end
endmodule
